/* dso_serial_out.sv */
// Dual channel serial sample output, control port gating, overrange, lock
//
// Contract
// - Each channel serialised on primary lane, clocked
// - Single lane: every sample on primary lane
// - Dual lane: every second sample on primary
// - Dual lane: alternate samples on secondary lane
// - Single lane: secondary lane high impedance
// - Lanes enabled; power-down freezes last level
// - Port enable selects control port over pins
// - Chip select active: clock shifts data in/out
// - Chip select idle: ignore input, tri-state output
// - Control data shifts with host serial clock
// - Overrange flag high when sample out of range
// - Lock high when locked, low on loss
// - One bit per bit clock edge
// - Primary at frame rise; secondary at fall when alignment low, at rise when high
// - Lane select low dual, high single
// - Alignment low offsets half word, high aligns
`timescale 1ns/10ps
`include "dso_defs.svh"
module dso_serial_out #(
   parameter int BIT_DIV = `DSO_BIT_DIV,
   parameter int LOCK_CYC = `DSO_LOCK_CYC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Converter core
   input wire dso_pkg::dso_sample_s i_chan_a_sample,
   input wire dso_pkg::dso_sample_s i_chan_b_sample,
   input wire logic i_sample_strobe,
   input wire logic i_clock_lost,
   // Direct configuration pins
   input wire logic i_lane_count_select,
   input wire logic i_word_alignment_select,
   input wire logic i_chan_a_power_down,
   input wire logic i_chan_b_power_down,
   input wire logic i_dll_reset,
   // Control port
   input wire logic i_ctrl_port_enable,
   input wire logic i_control_chip_select_n,
   input wire logic i_ctrl_sclk,
   input wire logic i_ctrl_sdi,
   output logic o_ctrl_sdo,
   output logic o_ctrl_sdo_oe_n,
   // Serial link
   output logic o_forwarded_bit_clock,
   output logic o_frame,
   output logic o_chan_a_primary_lane,
   output logic o_chan_b_primary_lane,
   output logic o_chan_a_secondary_lane,
   output logic o_chan_b_secondary_lane,
   output logic o_chan_a_secondary_lane_oe_n,
   output logic o_chan_b_secondary_lane_oe_n,
   // Status
   output logic o_chan_a_overrange,
   output logic o_chan_b_overrange,
   output logic o_dll_lock
);
   localparam int W = `DSO_SAMPLE_W;
   localparam int CW = `DSO_CFG_W;
   localparam int HALF = W / 2;

   // Pin synchronisers: a change counts once stages two and three agree
   logic [`DSO_SYN_W-1:0] syn_in, syn1, syn2, syn3, syn_q, next_syn_q;
   logic [`DSO_SYN_W-1:0] agree;
   assign syn_in = {i_dll_reset, i_chan_b_power_down, i_chan_a_power_down,
      i_word_alignment_select, i_lane_count_select, i_ctrl_port_enable,
      i_ctrl_sdi, i_control_chip_select_n, i_ctrl_sclk};
   always_comb begin
      agree = ~(syn2 ^ syn3);
      next_syn_q = (agree & syn3) | (~agree & syn_q);
   end
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         // Idle pattern in every stage: no false chip select after reset
         syn1 <= `DSO_SYN_RST;
         syn2 <= `DSO_SYN_RST;
         syn3 <= `DSO_SYN_RST;
         syn_q <= `DSO_SYN_RST;
      end else begin
         syn1 <= syn_in;
         syn2 <= syn1;
         syn3 <= syn2;
         syn_q <= next_syn_q;
      end
   end

   logic sclk_rise, sclk_fall, cs_act, port_en;
   assign sclk_rise = ~syn_q[`DSO_SYN_SCLK] & next_syn_q[`DSO_SYN_SCLK];
   assign sclk_fall = syn_q[`DSO_SYN_SCLK] & ~next_syn_q[`DSO_SYN_SCLK];
   assign cs_act = ~syn_q[`DSO_SYN_CS_N];
   assign port_en = syn_q[`DSO_SYN_PORT_EN];

   // Control port shifter
   dso_pkg::dso_cp_state_e cp, next_cp;
   logic [3:0] cp_cnt, next_cp_cnt;
   logic [CW-1:0] sh_in, next_sh_in, sh_out, next_sh_out;
   logic [CW-1:0] cfg, next_cfg;
   logic sdo, next_sdo, sdo_oe_n, next_sdo_oe_n;
   always_comb begin
      next_cp = cp;
      next_cp_cnt = cp_cnt;
      next_sh_in = sh_in;
      next_sh_out = sh_out;
      next_cfg = cfg;
      next_sdo = sdo;
      next_sdo_oe_n = sdo_oe_n;
      unique case (cp)
         dso_pkg::CP_IDLE: begin
            next_sdo_oe_n = 1'b1;
            if (cs_act && port_en) begin
               next_cp = dso_pkg::CP_SHIFT;
               next_cp_cnt = 4'h0;
               next_sh_out = {o_dll_lock, cfg[CW-2:0]};
               next_sdo = o_dll_lock;
               next_sdo_oe_n = 1'b0;
            end
         end
         dso_pkg::CP_SHIFT: begin
            if (!cs_act || !port_en) begin
               if (cp_cnt == 4'(CW)) begin
                  next_cfg = sh_in;
               end
               next_cp = dso_pkg::CP_IDLE;
               next_sdo_oe_n = 1'b1;
            end else begin
               if (sclk_rise && cp_cnt < 4'(CW)) begin
                  next_sh_in = {sh_in[CW-2:0], syn_q[`DSO_SYN_SDI]};
                  next_cp_cnt = cp_cnt + 4'h1;
               end
               if (sclk_fall) begin
                  next_sh_out = {sh_out[CW-2:0], 1'b0};
                  next_sdo = sh_out[CW-2];
               end
            end
         end
      endcase
   end
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cp <= dso_pkg::CP_IDLE;
         cp_cnt <= 4'h0;
         sh_in <= 8'h00;
         sh_out <= 8'h00;
         cfg <= `DSO_CFG_RST;
         sdo <= 1'b0;
         sdo_oe_n <= 1'b1;
      end else begin
         cp <= next_cp;
         cp_cnt <= next_cp_cnt;
         sh_in <= next_sh_in;
         sh_out <= next_sh_out;
         cfg <= next_cfg;
         sdo <= next_sdo;
         sdo_oe_n <= next_sdo_oe_n;
      end
   end
   assign o_ctrl_sdo = sdo;
   assign o_ctrl_sdo_oe_n = sdo_oe_n;

   // Effective configuration: port register or direct pins
   logic single, aligned;
   logic [1:0] pd;
   always_comb begin
      if (port_en) begin
         single = cfg[`DSO_CFG_LANE_BIT];
         aligned = cfg[`DSO_CFG_ALIGN_BIT];
         pd = {cfg[`DSO_CFG_PD_B_BIT], cfg[`DSO_CFG_PD_A_BIT]};
      end else begin
         single = syn_q[`DSO_SYN_LANE];
         aligned = syn_q[`DSO_SYN_ALIGN] & ~single;
         pd = {syn_q[`DSO_SYN_PD_B], syn_q[`DSO_SYN_PD_A]};
      end
   end

   // Serializer
   logic [15:0] div_cnt, next_div_cnt;
   logic [4:0] bit_cnt, next_bit_cnt, nb;
   logic bclk, next_bclk, frame, next_frame, tick;
   logic [W-1:0] hold_prev [2], next_hold_prev [2];
   logic [W-1:0] hold_cur [2], next_hold_cur [2];
   logic [W-1:0] psh [2], next_psh [2], ssh [2], next_ssh [2];
   logic [W-1:0] word;
   logic [1:0] pri, next_pri, sec, next_sec, sec_oe_n, next_sec_oe_n;
   logic [1:0] ovr, next_ovr;
   dso_pkg::dso_sample_s smp [2];
   assign smp[0] = i_chan_a_sample;
   assign smp[1] = i_chan_b_sample;
   always_comb begin
      tick = (div_cnt == 16'(BIT_DIV - 1));
      next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
      nb = (bit_cnt == 5'(W - 1)) ? 5'h00 : bit_cnt + 5'h01;
      next_bit_cnt = bit_cnt;
      next_bclk = bclk;
      next_frame = frame;
      word = '0;
      for (int c = 0; c < 2; c++) begin
         next_hold_prev[c] = hold_prev[c];
         next_hold_cur[c] = hold_cur[c];
         next_psh[c] = psh[c];
         next_ssh[c] = ssh[c];
         next_pri[c] = pri[c];
         next_sec[c] = sec[c];
         next_ovr[c] = ovr[c];
         next_sec_oe_n[c] = single;
         if (i_sample_strobe) begin
            next_hold_prev[c] = hold_cur[c];
            next_hold_cur[c] = smp[c].code;
            next_ovr[c] = smp[c].over_hi | smp[c].over_lo;
         end
         if (tick && !pd[c]) begin
            if (nb == 5'h00) begin
               word = single ? hold_cur[c] : hold_prev[c];
               next_pri[c] = word[W-1];
               next_psh[c] = {word[W-2:0], 1'b0};
            end else begin
               next_pri[c] = psh[c][W-1];
               next_psh[c] = {psh[c][W-2:0], 1'b0};
            end
            if (!single) begin
               if (nb == (aligned ? 5'h00 : 5'(HALF))) begin
                  next_sec[c] = hold_cur[c][W-1];
                  next_ssh[c] = {hold_cur[c][W-2:0], 1'b0};
               end else begin
                  next_sec[c] = ssh[c][W-1];
                  next_ssh[c] = {ssh[c][W-2:0], 1'b0};
               end
            end
         end
      end
      if (&pd) begin
         next_div_cnt = 16'h0000;
         next_bit_cnt = 5'(W - 1);
         next_bclk = 1'b0;
         next_frame = 1'b0;
      end else if (tick) begin
         next_bit_cnt = nb;
         next_bclk = ~bclk;
         next_frame = (nb < 5'(HALF));
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         div_cnt <= 16'h0000;
         bit_cnt <= 5'(W - 1);
         bclk <= 1'b0;
         frame <= 1'b0;
         pri <= 2'h0;
         sec <= 2'h0;
         sec_oe_n <= 2'h3;
         ovr <= 2'h0;
         for (int c = 0; c < 2; c++) begin
            hold_prev[c] <= '0;
            hold_cur[c] <= '0;
            psh[c] <= '0;
            ssh[c] <= '0;
         end
      end else begin
         div_cnt <= next_div_cnt;
         bit_cnt <= next_bit_cnt;
         bclk <= next_bclk;
         frame <= next_frame;
         pri <= next_pri;
         sec <= next_sec;
         sec_oe_n <= next_sec_oe_n;
         ovr <= next_ovr;
         for (int c = 0; c < 2; c++) begin
            hold_prev[c] <= next_hold_prev[c];
            hold_cur[c] <= next_hold_cur[c];
            psh[c] <= next_psh[c];
            ssh[c] <= next_ssh[c];
         end
      end
   end
   assign o_forwarded_bit_clock = bclk;
   assign o_frame = frame;
   assign o_chan_a_primary_lane = pri[0];
   assign o_chan_b_primary_lane = pri[1];
   assign o_chan_a_secondary_lane = sec[0];
   assign o_chan_b_secondary_lane = sec[1];
   assign o_chan_a_secondary_lane_oe_n = sec_oe_n[0];
   assign o_chan_b_secondary_lane_oe_n = sec_oe_n[1];
   assign o_chan_a_overrange = ovr[0];
   assign o_chan_b_overrange = ovr[1];

   // Delay-locked loop lock tracking
   dso_pkg::dso_dll_state_e dll, next_dll;
   logic [15:0] lock_cnt, next_lock_cnt;
   logic lock, next_lock;
   always_comb begin
      next_dll = dll;
      next_lock_cnt = lock_cnt;
      if (syn_q[`DSO_SYN_DLL_RST]) begin
         next_dll = dso_pkg::DLL_HOLD;
      end else begin
         unique case (dll)
            dso_pkg::DLL_HOLD: begin
               next_dll = dso_pkg::DLL_ACQ;
               next_lock_cnt = 16'h0000;
            end
            dso_pkg::DLL_ACQ: begin
               if (i_clock_lost) begin
                  next_lock_cnt = 16'h0000;
               end else if (lock_cnt == 16'(LOCK_CYC - 1)) begin
                  next_dll = dso_pkg::DLL_LOCKED;
               end else begin
                  next_lock_cnt = lock_cnt + 16'h0001;
               end
            end
            dso_pkg::DLL_LOCKED: begin
               if (i_clock_lost) begin
                  next_dll = dso_pkg::DLL_LOST;
               end
            end
            dso_pkg::DLL_LOST: begin
               next_dll = dso_pkg::DLL_LOST;
            end
         endcase
      end
      next_lock = (next_dll == dso_pkg::DLL_LOCKED);
   end
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dll <= dso_pkg::DLL_ACQ;
         lock_cnt <= 16'h0000;
         lock <= 1'b0;
      end else begin
         dll <= next_dll;
         lock_cnt <= next_lock_cnt;
         lock <= next_lock;
      end
   end
   assign o_dll_lock = lock;
endmodule : dso_serial_out

/* dso_defs.svh */
// Offsets, field positions, reset values and timing counts for dso
`ifndef DSO_DEFS_SVH
`define DSO_DEFS_SVH
`define DSO_SAMPLE_W 12
`define DSO_BIT_DIV 2
`define DSO_SYS_CLK_MHZ 200
`define DSO_LOCK_NS 5000
`define DSO_LOCK_CYC ((`DSO_LOCK_NS * `DSO_SYS_CLK_MHZ + 999) / 1000)
`define DSO_CFG_W 8
`define DSO_CFG_LANE_BIT 0
`define DSO_CFG_ALIGN_BIT 1
`define DSO_CFG_PD_A_BIT 2
`define DSO_CFG_PD_B_BIT 3
`define DSO_CFG_RST 8'h01
`define DSO_SYN_W 9
`define DSO_SYN_SCLK 0
`define DSO_SYN_CS_N 1
`define DSO_SYN_SDI 2
`define DSO_SYN_PORT_EN 3
`define DSO_SYN_LANE 4
`define DSO_SYN_ALIGN 5
`define DSO_SYN_PD_A 6
`define DSO_SYN_PD_B 7
`define DSO_SYN_DLL_RST 8
`define DSO_SYN_RST 9'h002
`endif

/* dso_pkg.sv */
// Types shared by the serial output interface
`include "dso_defs.svh"
package dso_pkg;
   typedef struct packed {
      logic [`DSO_SAMPLE_W-1:0] code;
      logic over_hi;
      logic over_lo;
   } dso_sample_s;

   typedef enum logic [0:0] {
      CP_IDLE = 1'b0,
      CP_SHIFT = 1'b1
   } dso_cp_state_e;

   typedef enum logic [1:0] {
      DLL_ACQ = 2'b00,
      DLL_LOCKED = 2'b01,
      DLL_LOST = 2'b10,
      DLL_HOLD = 2'b11
   } dso_dll_state_e;
endpackage : dso_pkg

/* dso_serial_out_sva.sv */
// Assertion checker for the serial output interface
`timescale 1ns/10ps
module dso_serial_out_sva #(
   parameter int BIT_DIV = 2,
   parameter int LOCK_CYC = 20
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Inputs
   input wire dso_pkg::dso_sample_s i_chan_a_sample,
   input wire dso_pkg::dso_sample_s i_chan_b_sample,
   input wire logic i_sample_strobe,
   input wire logic i_clock_lost,
   input wire logic i_dll_reset,
   input wire logic i_ctrl_port_enable,
   input wire logic i_control_chip_select_n,
   // Outputs
   input wire logic o_ctrl_sdo_oe_n,
   input wire logic o_forwarded_bit_clock,
   input wire logic o_frame,
   input wire logic o_chan_a_primary_lane,
   input wire logic o_chan_a_secondary_lane_oe_n,
   input wire logic o_chan_a_overrange,
   input wire logic o_chan_b_overrange,
   input wire logic o_dll_lock
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   a_sdo_released: assert property (
      i_control_chip_select_n [*8] |-> o_ctrl_sdo_oe_n)
      else $error("sdo driven while deselected");
   a_sdo_driven: assert property (
      (!i_control_chip_select_n && i_ctrl_port_enable) [*8] |-> !o_ctrl_sdo_oe_n)
      else $error("sdo not driven while selected");
   a_ovr_capture: assert property (i_sample_strobe |=>
      o_chan_a_overrange == ($past(i_chan_a_sample.over_hi) |
      $past(i_chan_a_sample.over_lo)))
      else $error("channel a overrange wrong");
   a_ovr_hold: assert property (
      !i_sample_strobe |=> $stable(o_chan_b_overrange))
      else $error("channel b overrange moved without strobe");
   a_lock_drop: assert property (
      i_clock_lost |-> ##[1:4] !o_dll_lock)
      else $error("lock kept after clock loss");
   a_lock_in_reset: assert property (
      i_dll_reset [*6] |-> !o_dll_lock)
      else $error("lock high during loop reset");
   a_lane_on_tick: assert property (
      $changed(o_chan_a_primary_lane) |-> $changed(o_forwarded_bit_clock))
      else $error("lane moved off a bit clock edge");
   a_frame_on_tick: assert property (
      $rose(o_frame) |-> $changed(o_forwarded_bit_clock))
      else $error("frame rose off a bit clock edge");
   c_lock: cover property ($rose(o_dll_lock));
   c_dual: cover property ($fell(o_chan_a_secondary_lane_oe_n));
   c_port: cover property ($fell(o_ctrl_sdo_oe_n));
endmodule : dso_serial_out_sva

/* dso_rx_model.sv */
// Receiver model: turns one serial lane back into sample words
`timescale 1ns/10ps
`include "dso_defs.svh"
module dso_rx_model (
   // Clock
   input wire logic i_clk,
   // Link
   input wire logic i_bclk,
   input wire logic i_frame,
   input wire logic i_lane,
   input wire logic i_start_fall,
   // Word out
   output logic [`DSO_SAMPLE_W-1:0] o_word
);
   logic bclk_q = 1'h0;
   logic frame_q = 1'h0;
   logic [`DSO_SAMPLE_W-1:0] sh = '0;
   logic [3:0] cnt = 4'h0;
   logic start;
   initial o_word = '0;
   assign start = i_frame != frame_q && i_frame != i_start_fall;
   // A bit on every bit clock edge, MSB first
   always @(posedge i_clk) begin
      bclk_q <= i_bclk;
      if (i_bclk != bclk_q) begin
         frame_q <= i_frame;
         sh <= {sh[`DSO_SAMPLE_W-2:0], i_lane};
         cnt <= start ? 4'h1 : cnt + 4'h1;
         if (!start && cnt == 4'hb) begin
            o_word <= {sh[`DSO_SAMPLE_W-2:0], i_lane};
         end
      end
   end
endmodule : dso_rx_model

/* dso_serial_out_tb.sv */
// Testbench for the serial output interface
`timescale 1ns/10ps
module dso_serial_out_tb;
   localparam int LOCK = 20;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   dso_pkg::dso_sample_s sa = '0;
   dso_pkg::dso_sample_s sb = '0;
   logic stb = 1'h0, lost = 1'h0, lane = 1'h1, align = 1'h0;
   logic pda = 1'h0, pdb = 1'h0, dllr = 1'h0, pen = 1'h0;
   logic cs_n = 1'h1, sclk = 1'h0, sdi = 1'h0;
   logic sdo, sdo_oe_n, bclk, frame, pa, pb, sca, scb, sca_oe_n, scb_oe_n;
   logic chan_a_overrange, chan_b_overrange, lock;
   logic [11:0] wpa, wpb, wsa, wsb;
   logic [7:0] rd;
   int err_count = 0;
   int checks_done = 0;
   always #2.5 clk = ~clk;
   dso_serial_out #(.BIT_DIV(2), .LOCK_CYC(LOCK)) uut (
      .i_sys_clk(clk), .i_reset_n(rst_n), .i_chan_a_sample(sa),
      .i_chan_b_sample(sb), .i_sample_strobe(stb), .i_clock_lost(lost),
      .i_lane_count_select(lane), .i_word_alignment_select(align),
      .i_chan_a_power_down(pda), .i_chan_b_power_down(pdb),
      .i_dll_reset(dllr), .i_ctrl_port_enable(pen),
      .i_control_chip_select_n(cs_n), .i_ctrl_sclk(sclk), .i_ctrl_sdi(sdi),
      .o_ctrl_sdo(sdo), .o_ctrl_sdo_oe_n(sdo_oe_n),
      .o_forwarded_bit_clock(bclk), .o_frame(frame),
      .o_chan_a_primary_lane(pa), .o_chan_b_primary_lane(pb),
      .o_chan_a_secondary_lane(sca), .o_chan_b_secondary_lane(scb),
      .o_chan_a_secondary_lane_oe_n(sca_oe_n),
      .o_chan_b_secondary_lane_oe_n(scb_oe_n), .o_chan_a_overrange(chan_a_overrange),
      .o_chan_b_overrange(chan_b_overrange), .o_dll_lock(lock));
   dso_rx_model rx_pa (.i_clk(clk), .i_bclk(bclk), .i_frame(frame),
      .i_lane(pa), .i_start_fall(1'h0), .o_word(wpa));
   dso_rx_model rx_pb (.i_clk(clk), .i_bclk(bclk), .i_frame(frame),
      .i_lane(pb), .i_start_fall(1'h0), .o_word(wpb));
   dso_rx_model rx_sa (.i_clk(clk), .i_bclk(bclk), .i_frame(frame),
      .i_lane(sca), .i_start_fall(!align), .o_word(wsa));
   dso_rx_model rx_sb (.i_clk(clk), .i_bclk(bclk), .i_frame(frame),
      .i_lane(scb), .i_start_fall(!align), .o_word(wsb));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wrap_up;
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic tk(input int n);
      repeat (n) @(negedge clk);
   endtask : tk
   // Two strobes: older word x, latest word y
   task automatic load(input logic [11:0] x, input logic [11:0] y);
      sa.code = x;
      sb.code = ~x;
      stb = 1'h1;
      tk(1);
      sa.code = y;
      sb.code = ~y;
      tk(1);
      stb = 1'h0;
   endtask : load
   task automatic spi(input logic [7:0] wr);
      cs_n = 1'h0;
      tk(16);
      check(sdo_oe_n, 1'h0);
      for (int i = 7; i >= 0; i--) begin
         sdi = wr[i];
         tk(16);
         rd[i] = sdo;
         sclk = 1'h1;
         tk(16);
         sclk = 1'h0;
      end
      tk(16);
      cs_n = 1'h1;
      sdi = ~sdi;
      tk(16);
      check(sdo_oe_n, 1'h1);
   endtask : spi
   task automatic t_single;
      load(12'h5a3, 12'h9c6);
      tk(100);
      check(wpa, 12'h9c6);
      check(wpb, 12'h639);
      check({sca_oe_n, scb_oe_n}, 2'h3);
   endtask : t_single
   task automatic t_dual(input logic al);
      lane = 1'h0;
      align = al;
      load(12'h3c1, 12'ha5e);
      tk(100);
      check(wpa, 12'h3c1);
      check(wpb, 12'hc3e);
      check(wsa, 12'ha5e);
      check(wsb, 12'h5a1);
      check({sca_oe_n, scb_oe_n}, 2'h0);
   endtask : t_dual
   task automatic t_ovr(input logic hi, input logic lo);
      sa.over_hi = hi;
      sb.over_lo = lo;
      stb = 1'h1;
      tk(1);
      stb = 1'h0;
      tk(2);
      check({chan_a_overrange, chan_b_overrange}, {hi, lo});
   endtask : t_ovr
   task automatic t_port;
      pen = 1'h1;
      spi(8'h00);
      check(rd, 8'h81);
      tk(8);
      check(sca_oe_n, 1'h0);
      spi(8'h01);
      check(rd, 8'h80);
      check(sca_oe_n, 1'h1);
      pen = 1'h0;
      lane = 1'h0;
      tk(8);
      check(sca_oe_n, 1'h0);
      lane = 1'h1;
      tk(8);
   endtask : t_port
   task automatic t_pd;
      int t;
      int m;
      logic v;
      t = 0;
      m = 0;
      pda = 1'h1;
      tk(8);
      v = pa;
      for (int i = 0; i < 60; i++) begin
         tk(1);
         m += int'(pa !== v);
         t += int'(bclk !== rx_pa.bclk_q);
      end
      check(16'(m), 16'h0);
      check(16'(t), 16'h1e);
      pdb = 1'h1;
      tk(8);
      check({bclk, frame}, 2'h0);
      pda = 1'h0;
      pdb = 1'h0;
   endtask : t_pd
   task automatic t_relock;
      lost = 1'h1;
      tk(1);
      lost = 1'h0;
      tk(40);
      check(lock, 1'h0);
      dllr = 1'h1;
      tk(200);
      dllr = 1'h0;
      tk(LOCK + 12);
      check(lock, 1'h1);
   endtask : t_relock
   initial begin
      tk(6);
      rst_n = 1'h1;
      tk(LOCK + 10);
      check(lock, 1'h1);
      t_single();
      t_dual(1'h0);
      t_dual(1'h1);
      lane = 1'h1;
      align = 1'h0;
      t_ovr(1'h1, 1'h1);
      t_ovr(1'h0, 1'h0);
      t_port();
      t_pd();
      t_relock();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      wrap_up();
   end
endmodule : dso_serial_out_tb
bind dso_serial_out dso_serial_out_sva #(.BIT_DIV(BIT_DIV),
   .LOCK_CYC(LOCK_CYC)) u_sva (.i_sys_clk, .i_reset_n, .i_chan_a_sample,
   .i_chan_b_sample, .i_sample_strobe, .i_clock_lost, .i_dll_reset,
   .i_ctrl_port_enable, .i_control_chip_select_n, .o_ctrl_sdo_oe_n,
   .o_forwarded_bit_clock, .o_frame, .o_chan_a_primary_lane,
   .o_chan_a_secondary_lane_oe_n, .o_chan_a_overrange, .o_chan_b_overrange,
   .o_dll_lock);
